// ---- hw/frs_cfg.svh ----
// offsets, field positions, reset values and timing counts for fault response select
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH
`define FRS_CTRL_OFFSET    8'hB4
`define FRS_CTRL_RESET     8'h00
`define FRS_FB_RESP_LO     0
`define FRS_FB_RESP_HI     1
`define FRS_AV_RESP_LO     4
`define FRS_AV_RESP_HI     5
`define FRS_SHORT_BIT      7
`define FRS_RESP_FLAG0     2'h0
`define FRS_RESP_HICCUP    2'h1
`define FRS_RESP_LATCH     2'h2
`define FRS_CLK_HZ         20000000
`define FRS_HICCUP_MS      500
`define FRS_HICCUP_CYCLES  ((`FRS_HICCUP_MS * (`FRS_CLK_HZ / 1000)))
`define FRS_TIMER_W        24
`define FRS_SYNC_W         7
`endif

// ---- hw/frs_pkg.sv ----
// types for fault response select
package frs_pkg;
  typedef enum logic [1:0] {RESP_FLAG, RESP_HICCUP, RESP_LATCH} frs_resp_type;
  typedef enum logic [1:0] {ST_RUN, ST_HICCUP, ST_LATCHED} frs_state_type;
endpackage

// ---- hw/frs_timer_if.sv ----
// carrier between the response logic and a hiccup restart timer
`timescale 1ns/1ps
interface frs_timer_if;
  logic arm;
  logic fault;
  logic done;
  modport ctrl  (output arm, output fault, input done);
  modport timer (input arm, input fault, output done);
endinterface

// ---- hw/frs_hiccup_timer.sv ----
// hiccup restart timer: counts while armed and fault clear, reloads on fault
`timescale 1ns/1ps
`include "frs_cfg.svh"
module frs_hiccup_timer #(
  parameter logic [`FRS_TIMER_W-1:0] PERIOD = `FRS_TIMER_W'(`FRS_HICCUP_CYCLES)
) (
  input  wire logic    ref_clk_in,
  input  wire logic    rst_in,
  frs_timer_if.timer   tif
);
  logic [`FRS_TIMER_W-1:0] count;
  logic [`FRS_TIMER_W-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (!tif.arm || tif.fault)
      next_count = PERIOD - `FRS_TIMER_W'(1);
    else if (count != '0)
      next_count = count - `FRS_TIMER_W'(1);
  end

  // done only after a full clear period; fault reappearing restarts the wait
  assign tif.done = tif.arm && !tif.fault && (count == '0);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      count <= '0;
    else
      count <= next_count;
  end
endmodule

// ---- hw/frs_top.sv ----
// Contract
// - response control byte, all bits rw, resets zero
// - global enable picks register fields, else mode pin
// - flyback overcurrent sets status, pulls fault flag low
// - flyback codes 00/11 flag only, keep switching
// - flyback hiccup/latch halts flyback and all phases
// - phases resume via soft-start after flyback recovery
// - flyback latch holds until chip enable toggles
// - average overcurrent sets status, pulls flag low
// - average codes 00/11 flag only, keep switching
// - average hiccup stops pwm, resumes after 500ms
// - average latch holds until pwm enable/enable toggle
// - fet short: latch, fail output, unless bit7 set
`timescale 1ns/1ps
`include "frs_cfg.svh"
module frs_top #(
  parameter logic [`FRS_TIMER_W-1:0] HICCUP_CYCLES = `FRS_TIMER_W'(`FRS_HICCUP_CYCLES)
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       global_resp_enable_in,
  input  wire logic       status_clear_in,
  input  wire logic       flyback_oc_in,
  input  wire logic       average_overcurrent_protection_in,
  input  wire logic       flyback_short_in,
  input  wire logic       chip_enable_in,
  input  wire logic       pwm_enable_in,
  input  wire logic [1:0] mode_resp_in,
  output logic            flyback_oc_status_out,
  output logic            average_oc_status_out,
  output logic            flyback_short_status_out,
  output logic            fault_flag_n_out,
  output logic            system_failure_n_out,
  output logic            flyback_enable_out,
  output logic            phase_outputs_enable_out,
  output logic            soft_start_out
);
  // fault, chip/pwm enable and mode pins pass two flops; first stage feeds only the second
  logic [`FRS_SYNC_W-1:0] sync1;
  logic [`FRS_SYNC_W-1:0] sync2;
  logic [`FRS_SYNC_W-1:0] pins;
  assign pins = {mode_resp_in, pwm_enable_in, chip_enable_in, flyback_short_in,
                 average_overcurrent_protection_in, flyback_oc_in};
  genvar gi;
  generate
    for (gi = 0; gi < `FRS_SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic       fb_oc;
  logic       av_oc;
  logic       fet_short;
  logic       chip_en;
  logic       pwm_en;
  logic [1:0] mode_code;
  assign fb_oc     = sync2[0];
  assign av_oc     = sync2[1];
  assign fet_short = sync2[2];
  assign chip_en   = sync2[3];
  assign pwm_en    = sync2[4];
  assign mode_code = sync2[6:5];

  function automatic frs_pkg::frs_resp_type resp_decode(input logic [1:0] code);
    if (code == `FRS_RESP_HICCUP)
      resp_decode = frs_pkg::RESP_HICCUP;
    else if (code == `FRS_RESP_LATCH)
      resp_decode = frs_pkg::RESP_LATCH;
    else
      resp_decode = frs_pkg::RESP_FLAG;
  endfunction

  logic                 [7:0] ctrl;
  logic                 [7:0] next_ctrl;
  logic                 [7:0] next_rdata;
  frs_pkg::frs_state_type     fb_state;
  frs_pkg::frs_state_type     next_fb_state;
  frs_pkg::frs_state_type     av_state;
  frs_pkg::frs_state_type     next_av_state;
  frs_pkg::frs_resp_type      fb_resp;
  frs_pkg::frs_resp_type      av_resp;
  logic                       short_flag_only;
  logic                       short_latch;
  logic                       next_short_latch;
  logic                       next_fb_stat;
  logic                       next_av_stat;
  logic                       next_sh_stat;
  logic                       next_fb_en;
  logic                       next_ph_en;
  logic                       next_soft;
  logic                       chip_en_d;
  logic                       pwm_en_d;
  logic                       en_toggle;
  logic                       pwm_toggle;

  frs_timer_if fb_tif ();
  frs_timer_if av_tif ();

  frs_hiccup_timer #(.PERIOD(HICCUP_CYCLES)) u_fb_timer (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .tif        (fb_tif)
  );
  frs_hiccup_timer #(.PERIOD(HICCUP_CYCLES)) u_av_timer (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .tif        (av_tif)
  );

  // register fields ignored while the global enable is low
  assign fb_resp = global_resp_enable_in ?
                   resp_decode(ctrl[`FRS_FB_RESP_HI:`FRS_FB_RESP_LO]) : resp_decode(mode_code);
  assign av_resp = global_resp_enable_in ?
                   resp_decode(ctrl[`FRS_AV_RESP_HI:`FRS_AV_RESP_LO]) : resp_decode(mode_code);
  assign short_flag_only = global_resp_enable_in ?
                           ctrl[`FRS_SHORT_BIT] : (resp_decode(mode_code) == frs_pkg::RESP_FLAG);

  // a falling edge on the enable counts as the toggle; recovery follows its return high
  assign en_toggle  = chip_en_d && !chip_en;
  assign pwm_toggle = pwm_en_d && !pwm_en;

  assign fb_tif.arm   = (fb_state == frs_pkg::ST_HICCUP);
  assign fb_tif.fault = fb_oc;
  assign av_tif.arm   = (av_state == frs_pkg::ST_HICCUP);
  assign av_tif.fault = av_oc;

  always_comb
  begin
    next_ctrl = ctrl;
    if (reg_wr_in && reg_addr_in == `FRS_CTRL_OFFSET)
      next_ctrl = reg_wdata_in;
    next_rdata = (reg_addr_in == `FRS_CTRL_OFFSET) ? next_ctrl : 8'h00;

    // set wins over clear on every status bit
    next_fb_stat = fb_oc || (flyback_oc_status_out && !status_clear_in);
    next_av_stat = av_oc || (average_oc_status_out && !status_clear_in);
    next_sh_stat = fet_short || (flyback_short_status_out && !status_clear_in);

    next_fb_state = fb_state;
    case (fb_state)
      frs_pkg::ST_RUN:
        if (fb_oc && fb_resp == frs_pkg::RESP_HICCUP)
          next_fb_state = frs_pkg::ST_HICCUP;
        else if (fb_oc && fb_resp == frs_pkg::RESP_LATCH)
          next_fb_state = frs_pkg::ST_LATCHED;
      frs_pkg::ST_HICCUP:
        if (fb_tif.done)
          next_fb_state = frs_pkg::ST_RUN;
      frs_pkg::ST_LATCHED:
        if (en_toggle)
          next_fb_state = frs_pkg::ST_RUN;
      default:
        next_fb_state = frs_pkg::ST_RUN;
    endcase

    next_av_state = av_state;
    case (av_state)
      frs_pkg::ST_RUN:
        if (av_oc && av_resp == frs_pkg::RESP_HICCUP)
          next_av_state = frs_pkg::ST_HICCUP;
        else if (av_oc && av_resp == frs_pkg::RESP_LATCH)
          next_av_state = frs_pkg::ST_LATCHED;
      frs_pkg::ST_HICCUP:
        if (av_tif.done)
          next_av_state = frs_pkg::ST_RUN;
      frs_pkg::ST_LATCHED:
        if (en_toggle || pwm_toggle)
          next_av_state = frs_pkg::ST_RUN;
      default:
        next_av_state = frs_pkg::ST_RUN;
    endcase

    next_short_latch = short_latch;
    if (fet_short && !short_flag_only)
      next_short_latch = 1'b1;
    else if (en_toggle)
      next_short_latch = 1'b0;

    next_fb_en = chip_en && (next_fb_state == frs_pkg::ST_RUN) && !next_short_latch;
    // phases need the flyback enabled in the same cycle, so they never beat it out of hiccup
    next_ph_en = next_fb_en && pwm_en && (next_av_state == frs_pkg::ST_RUN);
    next_soft  = next_ph_en && !phase_outputs_enable_out;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl                     <= `FRS_CTRL_RESET;
      reg_rdata_out            <= 8'h00;
      fb_state                 <= frs_pkg::ST_RUN;
      av_state                 <= frs_pkg::ST_RUN;
      short_latch              <= 1'b0;
      chip_en_d                <= 1'b0;
      pwm_en_d                 <= 1'b0;
      flyback_oc_status_out    <= 1'b0;
      average_oc_status_out    <= 1'b0;
      flyback_short_status_out <= 1'b0;
      fault_flag_n_out         <= 1'b1;
      system_failure_n_out     <= 1'b1;
      flyback_enable_out       <= 1'b0;
      phase_outputs_enable_out <= 1'b0;
      soft_start_out           <= 1'b0;
    end
    else
    begin
      ctrl                     <= next_ctrl;
      reg_rdata_out            <= next_rdata;
      fb_state                 <= next_fb_state;
      av_state                 <= next_av_state;
      short_latch              <= next_short_latch;
      chip_en_d                <= chip_en;
      pwm_en_d                 <= pwm_en;
      flyback_oc_status_out    <= next_fb_stat;
      average_oc_status_out    <= next_av_stat;
      flyback_short_status_out <= next_sh_stat;
      fault_flag_n_out         <= !(next_fb_stat || next_av_stat || next_sh_stat);
      system_failure_n_out     <= !next_short_latch;
      flyback_enable_out       <= next_fb_en;
      phase_outputs_enable_out <= next_ph_en;
      soft_start_out           <= next_soft;
    end
  end
endmodule

// ---- testbench/frs_checker.sv ----
// assertions on the fault response select ports
`timescale 1ns/1ps
module frs_checker (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       global_resp_enable_in,
  input wire logic       flyback_oc_in,
  input wire logic       average_overcurrent_protection_in,
  input wire logic       flyback_short_in,
  input wire logic       chip_enable_in,
  input wire logic [1:0] mode_resp_in,
  input wire logic       flyback_oc_status_out,
  input wire logic       average_oc_status_out,
  input wire logic       fault_flag_n_out,
  input wire logic       system_failure_n_out,
  input wire logic       flyback_enable_out,
  input wire logic       phase_outputs_enable_out,
  input wire logic       soft_start_out
);
  logic [7:0] ctrl;
  logic [1:0] fbc;
  logic [1:0] avc;
  logic       short_latch;
  // shadow of the control byte, so codes are known without peeking inside
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      ctrl <= 8'h00;
    else if (reg_wr_in && reg_addr_in == 8'hB4)
      ctrl <= reg_wdata_in;
  assign fbc         = global_resp_enable_in ? ctrl[1:0] : mode_resp_in;
  assign avc         = global_resp_enable_in ? ctrl[5:4] : mode_resp_in;
  assign short_latch = global_resp_enable_in ? !ctrl[7] : ^mode_resp_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // four quiet cycles cover the two-flop input sync
  sequence s_fb_quiet;
    (!(^fbc) && chip_enable_in && !flyback_short_in)[*4];
  endsequence
  AST_FB_STATUS: assert property ($rose(flyback_oc_in) |-> ##[2:4] flyback_oc_status_out)
    else $error("flyback status not set");
  AST_AV_STATUS: assert property ($rose(average_overcurrent_protection_in) |-> ##[2:4] average_oc_status_out)
    else $error("average status not set");
  AST_FLAG: assert property ((flyback_oc_status_out || average_oc_status_out) |-> ##[0:1] !fault_flag_n_out)
    else $error("fault flag not low");
  AST_FB_HALT: assert property ($rose(flyback_oc_in) && ^fbc |-> ##[2:4] !flyback_enable_out && !phase_outputs_enable_out)
    else $error("flyback fault did not halt");
  AST_AV_HALT: assert property ($rose(average_overcurrent_protection_in) && ^avc |-> ##[2:4] !phase_outputs_enable_out)
    else $error("average fault did not halt");
  AST_FB_KEEP: assert property (s_fb_quiet ##0 flyback_enable_out |=> flyback_enable_out)
    else $error("flag-only code stopped flyback");
  AST_SOFT: assert property ($rose(phase_outputs_enable_out) |-> soft_start_out)
    else $error("no soft start pulse");
  AST_REG_RB: assert property (reg_wr_in && reg_addr_in == 8'hB4 |=> reg_rdata_out == $past(reg_wdata_in))
    else $error("readback differs");
  AST_UNMAPPED: assert property (reg_addr_in != 8'hB4 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_SHORT: assert property ($rose(flyback_short_in) && short_latch |-> ##[2:4] !system_failure_n_out && !flyback_enable_out)
    else $error("short did not latch");
endmodule

// ---- testbench/frs_host_model.sv ----
// system controller model: register writes and enable pins
`timescale 1ns/1ps
module frs_host_model (
  input  wire logic       clk_in,
  input  wire logic       flyback_enable_in,
  output logic            wr_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            chip_enable_out,
  output logic            pwm_enable_out
);
  initial
  begin
    wr_out = 1'h0;
    addr_out = 8'hB4;
    wdata_out = 8'h00;
    chip_enable_out = 1'h1;
    pwm_enable_out = 1'h1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #5;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'h1;
    @(posedge clk_in);
    #5;
    wr_out = 1'h0;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    #5;
    addr_out = a;
    @(posedge clk_in);
    #5;
  endtask
  task automatic cycle_ce();
    chip_enable_out = 1'h0;
    repeat (4) @(posedge clk_in);
    #5;
    chip_enable_out = 1'h1;
  endtask
  // rails are taken as good once the flyback runs again
  task automatic cycle_pwm();
    int i;
    pwm_enable_out = 1'h0;
    repeat (4) @(posedge clk_in);
    #5;
    // look off the edge so the enable is settled; a stuck flyback still gets pwm back high after 100 cycles
    for (i = 0; i < 100 && flyback_enable_in !== 1'h1; i++)
    begin
      @(posedge clk_in);
      #5;
    end
    pwm_enable_out = 1'h1;
  endtask
endmodule

// ---- testbench/test_fault_response_select.sv ----
// self-checking bench for fault response select
`timescale 1ns/1ps
module test_fault_response_select;
  typedef struct packed {logic g; logic [7:0] c; logic [1:0] m; logic av; logic fbh; logic phh;} frs_row_type;
  localparam int HC = 20;
  logic        ref_clk_in, rst_in, wr, glob, clr, fb_oc, av_oc, fb_short, ce, pwm;
  logic [7:0]  addr, wdata, rdata;
  logic [1:0]  mode;
  logic        fb_st, av_st, sh_st, flag_n, fail_n, fb_en, ph_en, ss;
  int          errors, tests_run, n;
  frs_row_type r;
  frs_row_type rows [12] = '{
    {1'h1, 8'h00, 2'h0, 1'h0, 1'h0, 1'h0}, {1'h1, 8'h01, 2'h0, 1'h0, 1'h1, 1'h1},
    {1'h1, 8'h02, 2'h0, 1'h0, 1'h1, 1'h1}, {1'h1, 8'h03, 2'h0, 1'h0, 1'h0, 1'h0},
    {1'h1, 8'h00, 2'h0, 1'h1, 1'h0, 1'h0}, {1'h1, 8'h10, 2'h0, 1'h1, 1'h0, 1'h1},
    {1'h1, 8'h20, 2'h0, 1'h1, 1'h0, 1'h1}, {1'h1, 8'h30, 2'h0, 1'h1, 1'h0, 1'h0},
    {1'h0, 8'h01, 2'h0, 1'h0, 1'h0, 1'h0}, {1'h0, 8'h00, 2'h2, 1'h1, 1'h0, 1'h1},
    {1'h0, 8'h00, 2'h1, 1'h0, 1'h1, 1'h1}, {1'h0, 8'h20, 2'h3, 1'h1, 1'h0, 1'h0}};
  frs_top #(.HICCUP_CYCLES(24'(HC))) frs_top_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .global_resp_enable_in(glob),
    .status_clear_in(clr), .flyback_oc_in(fb_oc), .average_overcurrent_protection_in(av_oc),
    .flyback_short_in(fb_short), .chip_enable_in(ce), .pwm_enable_in(pwm), .mode_resp_in(mode),
    .flyback_oc_status_out(fb_st), .average_oc_status_out(av_st), .flyback_short_status_out(sh_st),
    .fault_flag_n_out(flag_n), .system_failure_n_out(fail_n), .flyback_enable_out(fb_en),
    .phase_outputs_enable_out(ph_en), .soft_start_out(ss));
  frs_host_model frs_host_model_inst (.clk_in(ref_clk_in), .flyback_enable_in(fb_en), .wr_out(wr),
    .addr_out(addr), .wdata_out(wdata), .chip_enable_out(ce), .pwm_enable_out(pwm));
  always #25 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #5;
  endtask
  // bounded wait for both enables; a hang ends the run
  task automatic wait_en();
    for (n = 0; !(fb_en === 1'h1 && ph_en === 1'h1); n++)
    begin
      if (n >= 200)
      begin
        errors++;
        test_done();
      end
      tick(1);
    end
  endtask
  task automatic recover();
    frs_host_model_inst.cycle_ce();
    frs_host_model_inst.cycle_pwm();
    clr = 1'h1;
    tick(1);
    clr = 1'h0;
    wait_en();
  endtask
  initial
  begin
    {ref_clk_in, rst_in, glob, clr, fb_oc, av_oc, fb_short, mode} = 9'h0C0;
    errors = 0;
    tests_run = 0;
    tick(12);
    chk({fb_st, av_st, sh_st, flag_n, fail_n, fb_en, ph_en, ss}, 8'h18);
    chk(rdata, 8'h00);
    rst_in = 1'h0;
    frs_host_model_inst.rd(8'hB4);
    chk(rdata, 8'h00);
    wait_en();
    foreach (rows[i])
    begin
      r = rows[i];
      glob = r.g;
      mode = r.m;
      frs_host_model_inst.wr(8'hB4, r.c);
      chk(rdata, r.c);
      tick(4);
      fb_oc = !r.av;
      av_oc = r.av;
      tick(6);
      chk(r.av ? av_st : fb_st, 1'h1);
      chk(flag_n, 1'h0);
      chk(fb_en, !r.fbh);
      chk(ph_en, !(r.fbh | r.phh));
      {fb_oc, av_oc, mode} = 4'h0;
      recover();
      chk(flag_n, 1'h1);
    end
    glob = 1'h1;
    // hiccup with a refault before expiry: timer must start over
    frs_host_model_inst.wr(8'hB4, 8'h01);
    fb_oc = 1'h1;
    tick(6);
    fb_oc = 1'h0;
    tick(12);
    chk(fb_en, 1'h0);
    fb_oc = 1'h1;
    tick(2);
    fb_oc = 1'h0;
    for (n = 0; fb_en !== 1'h1 && n < 200; n++) tick(1);
    chk(n >= HC && n <= HC + 6, 1'h1);
    chk({ph_en, ss}, 2'h3);
    recover();
    frs_host_model_inst.wr(8'hB4, 8'h02);
    fb_oc = 1'h1;
    tick(6);
    fb_oc = 1'h0;
    tick(HC * 3);
    chk(fb_en, 1'h0);
    recover();
    frs_host_model_inst.wr(8'hB4, 8'h20);
    av_oc = 1'h1;
    tick(6);
    av_oc = 1'h0;
    tick(HC * 3);
    chk({fb_en, ph_en}, 2'h2);
    frs_host_model_inst.cycle_pwm();
    tick(4);
    chk(ph_en, 1'h1);
    frs_host_model_inst.wr(8'hB4, 8'h10);
    av_oc = 1'h1;
    tick(6);
    av_oc = 1'h0;
    tick(HC - 4);
    chk(ph_en, 1'h0);
    tick(12);
    chk(ph_en, 1'h1);
    recover();
    // third pass: global off, pin code latches although the byte says flag only
    for (int k = 0; k < 3; k++)
    begin
      glob = (k != 2);
      mode = (k == 2) ? 2'h2 : 2'h0;
      frs_host_model_inst.wr(8'hB4, k ? 8'h80 : 8'h00);
      fb_short = 1'h1;
      tick(6);
      chk({sh_st, flag_n}, 2'h2);
      chk({fail_n, fb_en, ph_en}, (k == 1) ? 3'h7 : 3'h0);
      fb_short = 1'h0;
      mode = 2'h0;
      recover();
    end
    glob = 1'h1;
    frs_host_model_inst.wr(8'hB5, 8'h5A);
    chk(rdata, 8'h00);
    frs_host_model_inst.rd(8'hB4);
    chk(rdata, 8'h80);
    // mid-run reset must bring the byte back to zero
    rst_in = 1'h1;
    tick(2);
    chk({fb_st, av_st, sh_st, flag_n, fail_n, fb_en, ph_en, ss}, 8'h18);
    rst_in = 1'h0;
    frs_host_model_inst.rd(8'hB4);
    chk(rdata, 8'h00);
    wait_en();
    test_done();
  end
endmodule
bind frs_top frs_checker frs_checker_inst (.*);
